// File: hw/slc_defines.vh
// Constants for the solenoid lock control block
`ifndef SLC_DEFINES_VH
`define SLC_DEFINES_VH

// Register byte offsets on the Avalon slave
`define SLC_ADDR_CTRL 4'h0
`define SLC_ADDR_STATUS 4'h4
`define SLC_ADDR_PINS 4'h8

// Control register fields and reset value
`define SLC_CTRL_PN_BIT 0
`define SLC_CTRL_TEST_EN_BIT 1
`define SLC_CTRL_RESET 2'h2

// Status register field positions
`define SLC_ST_STATE_LSB 0
`define SLC_ST_PEND_BIT 4
`define SLC_ST_FAULT_BIT 5
`define SLC_ST_BOLT_BIT 6
`define SLC_ST_RETRY_BIT 7
`define SLC_ST_SAFE_A_BIT 8
`define SLC_ST_SAFE_B_BIT 9

// Clock rate and timing figures
`define SLC_CLK_MHZ 100
`define SLC_TEST_PULSE_US 400
`define SLC_TEST_PERIOD_MS 50
`define SLC_ATTEMPT_MS 500
`define SLC_FLASH_HALF_MS 500
`define SLC_INIT_WAIT 3'h7

// Derived cycle counts (pulse is a longest time: rounds down)
`define SLC_TEST_PULSE_CYC (`SLC_TEST_PULSE_US * `SLC_CLK_MHZ)
`define SLC_TEST_PERIOD_CYC (`SLC_TEST_PERIOD_MS * 1000 * `SLC_CLK_MHZ)
`define SLC_ATTEMPT_CYC (`SLC_ATTEMPT_MS * 1000 * `SLC_CLK_MHZ)
`define SLC_FLASH_HALF_CYC (`SLC_FLASH_HALF_MS * 1000 * `SLC_CLK_MHZ)

`endif

// File: hw/slc_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module slc_sync #(
  parameter W = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Pins and filtered result
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level_out
);
  reg [W-1:0] s1_q; // First stage, read by stage two only
  reg [W-1:0] s2_q; // Second stage
  reg [W-1:0] s3_q; // Third stage
  reg [W-1:0] lvl_q; // Accepted level
  genvar i;

  assign level_out = lvl_q;

  // One chain per bit; a change counts once stages two and three agree
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          lvl_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= pin_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // Agreement filter hides single-stage metastable glitches
          if (s2_q[i] == s3_q[i]) begin
            lvl_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule

// File: hw/slc_top.v
// Solenoid guard-lock control with Avalon-MM registers
//
// Summary of operation
// [R1] Decode command inputs into lock or unlock
// [R2] Failed first locking drive retries once itself
// [R3] Second failure enters and reports fault state
// [R4] Fault clears only after control inputs change
// [R5] Locked at power-on needs unlock then lock
// [R6] Yellow flashes until power-on cycle completes
// [R7] Safety outputs pulse off at most 0.4 ms
// [R8] Controller tolerates test dropouts up to 0.4 ms
// [R9] Controller blanks dropouts shorter than 1 ms
// [R10] Controller allows 100 ms channel discrepancy
// [R11] Controller has dual-channel semiconductor input
// [R12] Controller tests its own command outputs
// [R13] Safety outputs off unless bolt confirmed locked
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "slc_defines.vh"
module slc_top #(
  parameter [31:0] TEST_PULSE_CYC = `SLC_TEST_PULSE_CYC,
  parameter [31:0] TEST_PERIOD_CYC = `SLC_TEST_PERIOD_CYC,
  parameter [31:0] ATTEMPT_CYC = `SLC_ATTEMPT_CYC,
  parameter [31:0] FLASH_HALF_CYC = `SLC_FLASH_HALF_CYC
) (
  // Clock and reset
  input wire CLOCK_IN,
  input wire RESET_N_IN,
  // Avalon-MM slave
  input wire [3:0] AVS_ADDRESS_IN,
  input wire AVS_READ_IN,
  input wire AVS_WRITE_IN,
  input wire [31:0] AVS_WRITEDATA_IN,
  input wire [3:0] AVS_BYTEENABLE_IN,
  output wire [31:0] AVS_READDATA_OUT,
  output wire AVS_WAITREQUEST_OUT,
  // Command inputs from the safety controller
  input wire LOCK_CMD_IN_A_IN,
  input wire LOCK_CMD_IN_B_IN,
  input wire LOCK_CMD_RETURN_IN,
  // Bolt position sensor and drive
  input wire BOLT_LOCKED_IN,
  output wire BOLT_EXTEND_OUT,
  output wire BOLT_RETRACT_OUT,
  // Safety outputs and indicators
  output wire SAFE_OUT_A_OUT,
  output wire SAFE_OUT_B_OUT,
  output wire LED_YELLOW_OUT,
  output wire FAULT_OUT
);
  // Lock state machine codes
  localparam [2:0] S_INIT = 3'h0;
  localparam [2:0] S_UNLOCKED = 3'h1;
  localparam [2:0] S_EXTEND = 3'h2;
  localparam [2:0] S_LOCKED = 3'h3;
  localparam [2:0] S_RETRACT = 3'h4;
  localparam [2:0] S_FAULT = 3'h5;
  // Decoded command codes
  localparam [1:0] C_NONE = 2'h0;
  localparam [1:0] C_LOCK = 2'h1;
  localparam [1:0] C_UNLOCK = 2'h2;

  wire [3:0] pins; // Filtered pins: bolt, return, b, a
  wire cmd_a = pins[0];
  wire cmd_b = pins[1];
  wire cmd_ret = pins[2]; // High when return is tied to ground
  wire bolt = pins[3];
  reg [1:0] cmd; // Decoded command
  reg [1:0] ctrl_q; // Control register
  reg [2:0] state_q; // Lock state
  reg [2:0] init_q; // Settle wait after reset
  reg retry_q; // Second attempt in progress
  reg pend_q; // Power-on relock outstanding
  reg [31:0] tmr_q; // Attempt timer
  reg [2:0] fault_pins_q; // Input snapshot at fault entry
  reg [31:0] test_q; // Self-test period counter
  reg [31:0] flash_q; // Flash divider
  reg flash_en_q; // One-cycle divider enable
  reg led_q; // Yellow indicator
  reg safe_a_q; // Safety output A
  reg safe_b_q; // Safety output B
  reg ext_q; // Extend drive
  reg ret_q; // Retract drive
  reg fault_q; // Fault indicator
  reg wait_q; // Waitrequest
  reg [31:0] rdata_q; // Read data
  wire nominal_on; // Outputs would be on but for tests

  slc_sync #(.W(4)) u_sync (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESET_N_IN),
    .pin_in({BOLT_LOCKED_IN, LOCK_CMD_RETURN_IN, LOCK_CMD_IN_B_IN,
             LOCK_CMD_IN_A_IN}),
    .level_out(pins)
  );

  // Command decode for both variants; other patterns mean no change
  always @* begin
    cmd = C_NONE;
    if (ctrl_q[`SLC_CTRL_PN_BIT]) begin
      // A and B tied: lock needs return open too
      if (!cmd_a && !cmd_b && !cmd_ret) begin
        cmd = C_LOCK; // [R1]
      end else if (cmd_a && cmd_b && cmd_ret) begin
        cmd = C_UNLOCK; // [R1]
      end
    end else begin
      if (!cmd_a && !cmd_b && cmd_ret) begin
        cmd = C_LOCK; // [R1]
      end else if (cmd_a && cmd_b && cmd_ret) begin
        cmd = C_UNLOCK; // [R1]
      end
    end
  end

  // Lock state machine
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q <= S_INIT;
      init_q <= 3'h0;
      retry_q <= 1'b0;
      pend_q <= 1'b0;
      tmr_q <= 32'h0;
      fault_pins_q <= 3'h0;
    end else begin
      case (state_q)
        S_INIT: begin
          // Wait for the synchroniser before trusting the sensor
          init_q <= init_q + 3'h1;
          if (init_q == `SLC_INIT_WAIT) begin
            if (bolt) begin
              pend_q <= 1'b1; // [R5]
              state_q <= S_LOCKED;
            end else begin
              state_q <= S_UNLOCKED;
            end
          end
        end
        S_UNLOCKED: begin
          if (cmd == C_LOCK) begin
            retry_q <= 1'b0;
            tmr_q <= 32'h0;
            state_q <= S_EXTEND;
          end
        end
        S_EXTEND: begin
          tmr_q <= tmr_q + 32'h1;
          if (bolt) begin
            // Only reachable after an unlock, so power-on check is done
            pend_q <= 1'b0; // [R5]
            state_q <= S_LOCKED;
          end else if (cmd == C_UNLOCK) begin
            state_q <= S_RETRACT;
          end else if (tmr_q >= ATTEMPT_CYC - 32'h1) begin
            if (!retry_q) begin
              retry_q <= 1'b1; // [R2]
              tmr_q <= 32'h0; // [R2]
            end else begin
              fault_pins_q <= {cmd_ret, cmd_b, cmd_a}; // [R4]
              state_q <= S_FAULT; // [R3]
            end
          end
        end
        S_LOCKED: begin
          if (cmd == C_UNLOCK) begin
            state_q <= S_RETRACT;
          end
        end
        S_RETRACT: begin
          if (!bolt) begin
            state_q <= S_UNLOCKED;
          end
        end
        S_FAULT: begin
          // No drive until the controller changes the inputs
          if ({cmd_ret, cmd_b, cmd_a} != fault_pins_q) begin
            state_q <= S_RETRACT; // [R4]
          end
        end
        default: begin
          state_q <= S_INIT;
        end
      endcase
    end
  end

  // Outputs may be on only when locked and validated
  assign nominal_on = (state_q == S_LOCKED) && bolt && !pend_q;

  // Self-test period; A and B pulse at different times
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      test_q <= 32'h0;
    end else if (test_q >= TEST_PERIOD_CYC - 32'h1) begin
      test_q <= 32'h0;
    end else begin
      test_q <= test_q + 32'h1;
    end
  end

  // Safety outputs with cyclic off pulses
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      safe_a_q <= 1'b0;
      safe_b_q <= 1'b0;
    end else begin
      safe_a_q <= nominal_on; // [R13]
      safe_b_q <= nominal_on; // [R13]
      if (ctrl_q[`SLC_CTRL_TEST_EN_BIT]) begin
        // Staggered so the two channels never drop together
        if (test_q < TEST_PULSE_CYC) begin
          safe_a_q <= 1'b0; // [R7]
        end
        if (test_q >= (TEST_PERIOD_CYC >> 1) &&
            test_q < (TEST_PERIOD_CYC >> 1) + TEST_PULSE_CYC) begin
          safe_b_q <= 1'b0; // [R7]
        end
      end
    end
  end

  // Flash divider: enable pulse every half period
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      flash_q <= 32'h0;
      flash_en_q <= 1'b0;
    end else if (flash_q >= FLASH_HALF_CYC - 32'h1) begin
      flash_q <= 32'h0;
      flash_en_q <= 1'b1;
    end else begin
      flash_q <= flash_q + 32'h1;
      flash_en_q <= 1'b0;
    end
  end

  // Yellow indicator, drives and fault flag
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      led_q <= 1'b0;
      ext_q <= 1'b0;
      ret_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      if (!pend_q) begin
        led_q <= 1'b0;
      end else if (flash_en_q) begin
        led_q <= !led_q; // [R6]
      end
      ext_q <= (state_q == S_EXTEND);
      ret_q <= (state_q == S_RETRACT);
      fault_q <= (state_q == S_FAULT); // [R3]
    end
  end

  // Avalon slave: answer on the second edge, write at that edge
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      ctrl_q <= `SLC_CTRL_RESET;
    end else begin
      wait_q <= !((AVS_READ_IN || AVS_WRITE_IN) && wait_q);
      if (AVS_WRITE_IN && !wait_q && AVS_BYTEENABLE_IN[0] &&
          AVS_ADDRESS_IN == `SLC_ADDR_CTRL) begin
        ctrl_q <= AVS_WRITEDATA_IN[1:0];
      end
      if (AVS_READ_IN && wait_q) begin
        // Unmapped offsets read as zero
        case (AVS_ADDRESS_IN)
          `SLC_ADDR_CTRL: rdata_q <= {30'h0, ctrl_q};
          `SLC_ADDR_STATUS: rdata_q <= {22'h0, safe_b_q, safe_a_q,
                                        retry_q, bolt, fault_q, pend_q,
                                        1'b0, state_q};
          `SLC_ADDR_PINS: rdata_q <= {28'h0, pins};
          default: rdata_q <= 32'h0;
        endcase
      end
    end
  end

  assign AVS_READDATA_OUT = rdata_q;
  assign AVS_WAITREQUEST_OUT = wait_q;
  assign BOLT_EXTEND_OUT = ext_q;
  assign BOLT_RETRACT_OUT = ret_q;
  assign SAFE_OUT_A_OUT = safe_a_q;
  assign SAFE_OUT_B_OUT = safe_b_q;
  assign LED_YELLOW_OUT = led_q;
  assign FAULT_OUT = fault_q;
endmodule

// File: verif/slc_props.sv
// Checker on the lock control top ports
`timescale 1ns/1ps
module slc_props #(
  parameter [31:0] TEST_PULSE_CYC = 4,
  parameter [31:0] ATTEMPT_CYC = 50
) (
  input wire CLOCK_IN,
  input wire RESET_N_IN,
  input wire AVS_WAITREQUEST_OUT,
  input wire LOCK_CMD_IN_A_IN,
  input wire LOCK_CMD_IN_B_IN,
  input wire LOCK_CMD_RETURN_IN,
  input wire BOLT_EXTEND_OUT,
  input wire BOLT_RETRACT_OUT,
  input wire SAFE_OUT_A_OUT,
  input wire SAFE_OUT_B_OUT,
  input wire LED_YELLOW_OUT,
  input wire FAULT_OUT
);
  reg [31:0] la_q; // A dropped while B on
  reg [31:0] lb_q; // B dropped while A on
  reg [31:0] ex_q; // Run of lock drive
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // Run lengths; a real switch-off drops both
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      la_q <= 0;
      lb_q <= 0;
      ex_q <= 0;
    end else begin
      la_q <= (!SAFE_OUT_A_OUT && SAFE_OUT_B_OUT) ? la_q + 1 : 0;
      lb_q <= (!SAFE_OUT_B_OUT && SAFE_OUT_A_OUT) ? lb_q + 1 : 0;
      ex_q <= BOLT_EXTEND_OUT ? ex_q + 1 : 0;
    end
  end
  fault_safe_a: assert property (FAULT_OUT |->
    !SAFE_OUT_A_OUT && !SAFE_OUT_B_OUT) else $error("safe on in fault");
  // Drive and outputs are both registered from the same state
  drive_safe_a: assert property ((BOLT_EXTEND_OUT || BOLT_RETRACT_OUT)
    |-> !SAFE_OUT_A_OUT && !SAFE_OUT_B_OUT) else $error("safe on moving");
  pulse_a_a: assert property (la_q <= TEST_PULSE_CYC)
    else $error("A test pulse too long");
  pulse_b_a: assert property (lb_q <= TEST_PULSE_CYC)
    else $error("B test pulse too long");
  retry_len_a: assert property ($rose(FAULT_OUT) |->
    ex_q + 8 >= 2 * ATTEMPT_CYC && ex_q <= 2 * ATTEMPT_CYC + 8)
    else $error("fault not after two attempts");
  fault_hold_a: assert property ((FAULT_OUT && $stable({LOCK_CMD_IN_A_IN,
    LOCK_CMD_IN_B_IN, LOCK_CMD_RETURN_IN}))[*8] |=> FAULT_OUT)
    else $error("fault left without input change");
  fault_exit_a: assert property ($fell(FAULT_OUT) |-> BOLT_RETRACT_OUT)
    else $error("fault exit not via retract");
  flash_safe_a: assert property ($rose(LED_YELLOW_OUT) |->
    !SAFE_OUT_A_OUT && !SAFE_OUT_B_OUT) else $error("safe on while flash");
  wait_one_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low too long");
endmodule
bind slc_top slc_props #(.TEST_PULSE_CYC(TEST_PULSE_CYC),
  .ATTEMPT_CYC(ATTEMPT_CYC)) u_props (.CLOCK_IN, .RESET_N_IN,
  .AVS_WAITREQUEST_OUT, .LOCK_CMD_IN_A_IN, .LOCK_CMD_IN_B_IN,
  .LOCK_CMD_RETURN_IN, .BOLT_EXTEND_OUT, .BOLT_RETRACT_OUT,
  .SAFE_OUT_A_OUT, .SAFE_OUT_B_OUT, .LED_YELLOW_OUT, .FAULT_OUT);

// File: verif/slc_ctrl_model.sv
// Safety controller, monitoring input and bolt mechanics model
`timescale 1ns/1ps
module slc_ctrl_model #(
  parameter [31:0] BLANK_CYC = 100000, // 1 ms blanking at 100 MHz
  parameter [31:0] DISC_CYC = 10000000 // 100 ms discrepancy window
) (
  input wire clk_in,
  input wire preset_in, // Bolt starts locked
  input wire unlock_in, // Requested command
  input wire pn_in, // Wired as P/N variant
  input wire jam_in, // Bolt blocked by the guard
  input wire extend_in,
  input wire retract_in,
  input wire safe_a_in,
  input wire safe_b_in,
  output wire cmd_a_out,
  output wire cmd_b_out,
  output wire cmd_ret_out,
  output wire demand_out, // Safety demand after blanking
  output wire disc_out, // Channels disagreed too long
  output reg bolt_out
);
  reg [3:0] cnt_q; // Travel time
  reg [31:0] off_a_q; // Off run of channel A, saturating
  reg [31:0] off_b_q; // Off run of channel B, saturating
  reg [31:0] disc_q; // Disagreement run, saturating
  wire seen_a; // Channel A after blanking
  wire seen_b; // Channel B after blanking
  // Pin patterns of both variants
  assign cmd_a_out = unlock_in;
  assign cmd_b_out = unlock_in;
  assign cmd_ret_out = unlock_in | !pn_in;
  // Dropouts shorter than the blanking time are not seen
  assign seen_a = safe_a_in || (off_a_q < BLANK_CYC - 1);
  assign seen_b = safe_b_in || (off_b_q < BLANK_CYC - 1);
  // A blanked test dropout is no demand
  assign demand_out = !(seen_a && seen_b);
  assign disc_out = (disc_q >= DISC_CYC);
  // Run counters; a fresh start counts as a long off time
  always @(posedge clk_in or posedge preset_in) begin
    if (preset_in) begin
      off_a_q <= BLANK_CYC;
      off_b_q <= BLANK_CYC;
      disc_q <= 32'h0;
    end else begin
      off_a_q <= safe_a_in ? 32'h0 : off_a_q + {31'h0, off_a_q < BLANK_CYC};
      off_b_q <= safe_b_in ? 32'h0 : off_b_q + {31'h0, off_b_q < BLANK_CYC};
      disc_q <= (seen_a != seen_b) ?
                disc_q + {31'h0, disc_q < DISC_CYC} : 32'h0;
    end
  end
  // Ten cycles of travel; a jammed bolt never locks
  always @(posedge clk_in or posedge preset_in) begin
    if (preset_in) begin
      bolt_out <= 1'b1;
      cnt_q <= 4'h0;
    end else if (extend_in == retract_in) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h9) begin
        bolt_out <= extend_in & !jam_in;
      end
    end
  end
endmodule

// File: verif/solenoid_lock_control_bench.sv
// Bench for the solenoid lock control block
`timescale 1ns/1ps
`include "slc_defines.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  miscompares++; $display("Error %0t: %h not %h", $time, a, e); end end
module solenoid_lock_control_bench;
  reg clk = 0;
  reg rst_n = 0;
  reg [3:0] adr = 0;
  reg rd = 0;
  reg wr = 0;
  reg [31:0] wd = 0;
  reg [3:0] be = 4'hf;
  reg pre = 1, unl = 0, pn = 0, jam = 0, l;
  reg [31:0] v;
  wire [31:0] rdat;
  wire wt, ext, ret, sa, sb, led, flt, ca, cb, cr, bolt, dem, dsc;
  integer miscompares = 0, samples_checked = 0, cyc = 0, i, na, nb, nd;
  always #5 clk = ~clk;
  slc_top #(.TEST_PULSE_CYC(4), .TEST_PERIOD_CYC(100), .ATTEMPT_CYC(50),
    .FLASH_HALF_CYC(20)) dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wt),
    .LOCK_CMD_IN_A_IN(ca), .LOCK_CMD_IN_B_IN(cb), .LOCK_CMD_RETURN_IN(cr),
    .BOLT_LOCKED_IN(bolt), .BOLT_EXTEND_OUT(ext), .BOLT_RETRACT_OUT(ret),
    .SAFE_OUT_A_OUT(sa), .SAFE_OUT_B_OUT(sb), .LED_YELLOW_OUT(led),
    .FAULT_OUT(flt));
  // Scaled like the block: blanking 10 against a 4-cycle pulse
  slc_ctrl_model #(.BLANK_CYC(10), .DISC_CYC(200)) model (.clk_in(clk),
    .preset_in(pre), .unlock_in(unl), .pn_in(pn), .jam_in(jam),
    .extend_in(ext), .retract_in(ret), .safe_a_in(sa), .safe_b_in(sb),
    .cmd_a_out(ca), .cmd_b_out(cb), .cmd_ret_out(cr), .demand_out(dem),
    .disc_out(dsc), .bolt_out(bolt));
  // One bus cycle, held until waitrequest is seen low
  task av(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wt !== 1'b0) @(posedge clk);
      v = rdat;
      wr <= 0;
      rd <= 0;
    end
  endtask
  // Poll the state field, bounded
  task st(input [2:0] e);
    begin
      av(0, `SLC_ADDR_STATUS, 0);
      for (i = 0; i < 40 && v[2:0] !== e; i++) av(0, `SLC_ADDR_STATUS, 0);
      `CHK(v[2:0], e)
    end
  endtask
  task t_regs;
    begin
      av(0, `SLC_ADDR_CTRL, 0);
      `CHK(v[1:0], `SLC_CTRL_RESET)
      // Lane 0 disabled: the control write must be ignored
      be <= 4'h0;
      av(1, `SLC_ADDR_CTRL, 32'h1);
      be <= 4'hf;
      av(0, `SLC_ADDR_CTRL, 0);
      `CHK(v[1:0], `SLC_CTRL_RESET)
      av(1, 4'hc, 32'hff);
      av(0, 4'hc, 0);
      `CHK(v, 32'h0)
      $display("register test done");
    end
  endtask
  task t_power;
    begin
      st(3);
      `CHK(v[`SLC_ST_PEND_BIT], 1'b1)
      `CHK(v[9:8], 2'h0)
      // Any 40 edges hold exactly two toggles of a 20-cycle half period
      l = led;
      na = 0;
      repeat (40) begin
        @(posedge clk);
        na += (led !== l);
        l = led;
      end
      `CHK(na, 2)
      unl <= 1;
      st(1);
      unl <= 0;
      st(3);
      `CHK(v[`SLC_ST_PEND_BIT], 1'b0)
      $display("power-on test done");
    end
  endtask
  task t_pulse;
    begin
      // Let a pulse cut short by switch-on pass first
      repeat (10) @(posedge clk);
      na = 0;
      nb = 0;
      nd = 0;
      repeat (100) begin
        @(posedge clk);
        na += !sa;
        nb += !sb;
        nd += dem;
      end
      `CHK(na, 4)
      `CHK(nb, 4)
      `CHK(nd, 0)
      `CHK(dsc, 1'b0)
      // Self-test disabled: neither channel may drop
      av(1, `SLC_ADDR_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      na = 0;
      repeat (100) begin
        @(posedge clk);
        na += !sa + !sb;
      end
      `CHK(na, 0)
      av(1, `SLC_ADDR_CTRL, `SLC_CTRL_RESET);
      $display("pulse test done");
    end
  endtask
  task t_fault;
    begin
      unl <= 1;
      st(1);
      jam <= 1;
      unl <= 0;
      repeat (80) @(posedge clk);
      av(0, `SLC_ADDR_STATUS, 0);
      `CHK({v[`SLC_ST_RETRY_BIT], flt, ext}, 3'b101)
      for (i = 0; i < 60 && flt !== 1'b1; i++) @(posedge clk);
      `CHK(flt, 1'b1)
      repeat (30) @(posedge clk);
      `CHK({flt, ext}, 2'b10)
      `CHK(dem, 1'b1)
      jam <= 0;
      unl <= 1;
      st(1);
      `CHK(flt, 1'b0)
      $display("fault test done");
    end
  endtask
  task t_pn;
    begin
      av(1, `SLC_ADDR_CTRL, 32'h3);
      unl <= 0;
      repeat (40) @(posedge clk);
      st(1);
      pn <= 1;
      st(3);
      // Block's pins register reads back the controller's command outputs and the bolt sensor
      av(0, `SLC_ADDR_PINS, 0);
      `CHK(v[3:0], {bolt, cr, cb, ca})
      unl <= 1;
      st(1);
      $display("variant test done");
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    pre <= 0;
    t_regs;
    t_power;
    t_pulse;
    t_fault;
    t_pn;
    end_of_test;
  end
endmodule
